// *** mabc_pkg.sv ***
// Package with the register map, field layout, area bounds and types of the bus-cycle control.
`default_nettype none
package mabc_pkg;
    localparam logic [11:0] OFF_MODE = 12'h000;
    localparam logic [11:0] OFF_WAIT = 12'h004;
    localparam logic [11:0] OFF_STAT = 12'h008;
    localparam logic [7:0] MODE_RST = 8'h04;
    localparam logic [7:0] MODE_WMASK = 8'h67;
    localparam logic [15:0] WAIT_RST = 16'h0000;
    localparam logic [15:0] WAIT_WMASK = 16'hC0FF;
    localparam int MODE_SIZE_LSB = 0;
    localparam int MODE_EXT16_BIT = 5;
    localparam int MODE_EXTEN_BIT = 6;
    localparam int AW_LO_BIT = 0;
    localparam int AW_HI_BIT = 1;
    localparam int ROM_WAIT_LSB = 2;
    localparam int EXT_WAIT_LSB = 4;
    localparam int SFR_WAIT_LSB = 6;
    localparam int HSF_INT_BIT = 14;
    localparam int HSF_EXT_BIT = 15;
    localparam logic [15:0] PRAM_LO = 16'hF700;
    localparam logic [15:0] PRAM_LO_SMALL = 16'hFC00;
    localparam logic [15:0] PRAM_HI = 16'hFDFF;
    localparam logic [15:0] MRAM_LO = 16'hFE00;
    localparam logic [15:0] MRAM_HI = 16'hFEFF;
    localparam logic [15:0] XSFR_LO = 16'hFFD0;
    localparam logic [15:0] XSFR_HI = 16'hFFDF;
    localparam logic [15:0] ISFR_LO = 16'hFF00;
    localparam logic [2:0] MAIN_RAM_CYCLES = 3'd2;
    localparam logic [2:0] ONE_CYCLE = 3'd1;
    localparam logic [2:0] SYNC_CYCLES = 3'd2;

    typedef enum logic [2:0] {
        AREA_ROM = 3'b000,
        AREA_PRAM = 3'b001,
        AREA_MRAM = 3'b010,
        AREA_XSFR = 3'b011,
        AREA_ISFR = 3'b100,
        AREA_EXT = 3'b101
    } mabc_area_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_AWAIT = 2'b10,
        ST_DATA = 2'b11
    } mabc_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic fetch;
        logic write;
        logic [15:0] wdata;
    } mabc_req_t;

    typedef struct packed {
        logic [15:0] rdata;
        logic fault;
    } mabc_resp_t;
endpackage
`default_nettype wire

// *** mabc_top.sv ***
// Bus-cycle control: area decode, fetch mode, wait insertion and external strobes.
`timescale 1ns/100ps
`default_nettype none
module mabc_top #(
    parameter bit SMALL_VARIANT = 1'b0
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic REQ_VALID,
    input wire mabc_pkg::mabc_req_t REQ,
    output logic REQ_READY,
    output logic RESP_VALID,
    output mabc_pkg::mabc_resp_t RESP,
    output logic INT_SEL,
    output logic INT_WRITE,
    output logic [15:0] INT_ADDR,
    input wire logic [15:0] INT_RDATA,
    output logic [15:0] EXT_AD_O,
    output logic EXT_AD_OE_N,
    input wire logic [15:0] EXT_AD_I,
    output logic EXT_ASTB,
    output logic EXT_RD_N,
    output logic EXT_WR_N,
    output logic EXT_CTRL_OE_N,
    output logic EXT_WIDTH16,
    input wire logic WATCHDOG_TIMEOUT_IN,
    output logic WATCHDOG_TIMEOUT_OUT
);
    import mabc_pkg::*;

    logic [7:0] memory_expansion_mode_reg;
    logic [7:0] next_memory_expansion_mode_reg;
    logic [15:0] programmable_wait_ctrl_reg;
    logic [15:0] next_programmable_wait_ctrl_reg;
    logic [31:0] prdata_mux;
    logic apb_wr;
    logic hit;
    logic [15:0] ad_meta;
    logic [15:0] ad_sync;

    mabc_state_t state;
    mabc_state_t next_state;
    mabc_area_t area;
    mabc_area_t cur_area;
    mabc_area_t next_cur_area;
    logic [15:0] cur_addr;
    logic [15:0] next_cur_addr;
    logic cur_write;
    logic next_cur_write;
    logic [15:0] cur_wdata;
    logic [15:0] next_cur_wdata;
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic resp_valid;
    logic next_resp_valid;
    mabc_resp_t resp;
    mabc_resp_t next_resp;
    logic fault_seen;
    logic next_fault_seen;

    logic [15:0] rom_top;
    logic [15:0] pram_lo;
    logic is_ext;
    logic hsf;
    logic aw;
    logic [1:0] waits;
    logic [2:0] base;
    logic refuse;
    logic [2:0] sync_pad;
    logic is_ext_cur;

    // The size field sets the top of internal ROM in 8K steps; zero means none.
    assign rom_top = {memory_expansion_mode_reg[MODE_SIZE_LSB +: 3], 13'h0000};
    assign pram_lo = SMALL_VARIANT ? PRAM_LO_SMALL : PRAM_LO;

    // Area decode of the requested address.
    always_comb begin
        if (REQ.addr >= MRAM_LO && REQ.addr <= MRAM_HI) begin
            area = AREA_MRAM;
        end else if (REQ.addr >= pram_lo && REQ.addr <= PRAM_HI) begin
            area = AREA_PRAM;
        end else if (REQ.addr >= XSFR_LO && REQ.addr <= XSFR_HI) begin
            area = AREA_XSFR;
        end else if (REQ.addr >= ISFR_LO) begin
            area = AREA_ISFR;
        end else if (REQ.addr < rom_top) begin
            area = AREA_ROM;
        end else begin
            area = AREA_EXT;
        end
    end

    // Per-area fetch mode, address wait, wait count and base data cycles.
    always_comb begin
        is_ext = 1'b0;
        hsf = 1'b0;
        aw = 1'b0;
        waits = 2'b00;
        base = ONE_CYCLE;
        refuse = 1'b0;
        sync_pad = 3'd0;
        case (area)
            AREA_ROM: begin
                hsf = REQ.fetch & programmable_wait_ctrl_reg[HSF_INT_BIT];
                aw = programmable_wait_ctrl_reg[AW_LO_BIT];
                waits = programmable_wait_ctrl_reg[ROM_WAIT_LSB +: 2];
            end
            AREA_PRAM: begin
                hsf = REQ.fetch;
            end
            AREA_MRAM: begin
                refuse = REQ.fetch;
                base = MAIN_RAM_CYCLES;
            end
            AREA_XSFR: begin
                is_ext = 1'b1;
                waits = programmable_wait_ctrl_reg[SFR_WAIT_LSB +: 2];
            end
            AREA_EXT: begin
                is_ext = 1'b1;
                hsf = REQ.fetch & programmable_wait_ctrl_reg[HSF_EXT_BIT];
                aw = programmable_wait_ctrl_reg[AW_HI_BIT];
                waits = programmable_wait_ctrl_reg[EXT_WAIT_LSB +: 2];
            end
            default: begin
                hsf = 1'b0;
            end
        endcase
        // External reads hold the strobe two more cycles so the synchronised pins carry data.
        if (is_ext & ~REQ.write) begin
            sync_pad = SYNC_CYCLES;
        end
    end

    // APB slave: zero-wait answer, error on unmapped offsets.
    assign PREADY = 1'b1;
    assign apb_wr = PSEL & PENABLE & PWRITE;
    assign hit = (PADDR == OFF_MODE) || (PADDR == OFF_WAIT) || (PADDR == OFF_STAT);
    assign PSLVERR = PSEL & PENABLE & ~hit;

    always_comb begin
        case (PADDR)
            OFF_MODE: prdata_mux = {24'h00_0000, memory_expansion_mode_reg};
            OFF_WAIT: prdata_mux = {16'h0000, programmable_wait_ctrl_reg};
            OFF_STAT: prdata_mux = {26'h000_0000, fault_seen, cur_area, state};
            default: prdata_mux = 32'h0000_0000;
        endcase
        PRDATA = (PSEL & PENABLE) ? prdata_mux : 32'h0000_0000;
    end

    always_comb begin
        next_memory_expansion_mode_reg = memory_expansion_mode_reg;
        next_programmable_wait_ctrl_reg = programmable_wait_ctrl_reg;
        if (apb_wr && PADDR == OFF_MODE) begin
            next_memory_expansion_mode_reg = PWDATA[7:0] & MODE_WMASK;
        end
        if (apb_wr && PADDR == OFF_WAIT) begin
            next_programmable_wait_ctrl_reg = PWDATA[15:0] & WAIT_WMASK;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            memory_expansion_mode_reg <= MODE_RST;
            programmable_wait_ctrl_reg <= WAIT_RST;
        end else begin
            memory_expansion_mode_reg <= next_memory_expansion_mode_reg;
            programmable_wait_ctrl_reg <= next_programmable_wait_ctrl_reg;
        end
    end

    always_ff @(posedge CLK) begin
        ad_meta <= EXT_AD_I;
        ad_sync <= ad_meta;
    end

    // Cycle sequencer: address phase, optional address wait, data phase with waits.
    assign REQ_READY = (state == ST_IDLE) & ~RST;

    always_comb begin
        next_state = state;
        next_cur_area = cur_area;
        next_cur_addr = cur_addr;
        next_cur_write = cur_write;
        next_cur_wdata = cur_wdata;
        next_cnt = cnt;
        next_resp_valid = 1'b0;
        next_resp = resp;
        next_fault_seen = fault_seen;
        case (state)
            ST_IDLE: begin
                if (REQ_VALID) begin
                    next_cur_area = area;
                    next_cur_addr = REQ.addr;
                    next_cur_write = REQ.write;
                    next_cur_wdata = REQ.wdata;
                    next_cnt = {2'b00, base} + {3'b000, waits} + {2'b00, sync_pad} - 5'd1;
                    if (refuse) begin
                        next_resp_valid = 1'b1;
                        next_resp = '{rdata: 16'h0000, fault: 1'b1};
                        next_fault_seen = 1'b1;
                    end else if (hsf) begin
                        next_state = aw ? ST_AWAIT : ST_DATA;
                    end else begin
                        next_state = ST_ADDR;
                    end
                    if (aw) begin
                        next_cnt[4] = 1'b1;
                    end
                end
            end
            ST_ADDR: begin
                next_state = cnt[4] ? ST_AWAIT : ST_DATA;
            end
            ST_AWAIT: begin
                next_cnt[4] = 1'b0;
                next_state = ST_DATA;
            end
            ST_DATA: begin
                next_cnt[4] = 1'b0;
                if (cnt[3:0] == 4'd0) begin
                    next_state = ST_IDLE;
                    next_resp_valid = 1'b1;
                    next_resp.fault = 1'b0;
                    next_resp.rdata = (cur_area == AREA_XSFR || cur_area == AREA_EXT)
                                      ? ad_sync : INT_RDATA;
                end else begin
                    next_cnt = cnt - 5'd1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state <= ST_IDLE;
            cur_area <= AREA_ROM;
            cur_addr <= 16'h0000;
            cur_write <= 1'b0;
            cur_wdata <= 16'h0000;
            cnt <= 5'd0;
            resp_valid <= 1'b0;
            resp <= '0;
            fault_seen <= 1'b0;
        end else begin
            state <= next_state;
            cur_area <= next_cur_area;
            cur_addr <= next_cur_addr;
            cur_write <= next_cur_write;
            cur_wdata <= next_cur_wdata;
            cnt <= next_cnt;
            resp_valid <= next_resp_valid;
            resp <= next_resp;
            fault_seen <= next_fault_seen;
        end
    end

    assign RESP_VALID = resp_valid;
    assign RESP = resp;

    // Internal memory strobes and external bus pins.
    always_comb begin
        is_ext_cur = (cur_area == AREA_XSFR) || (cur_area == AREA_EXT);
        INT_SEL = (state == ST_DATA) & ~is_ext_cur;
        INT_WRITE = INT_SEL & cur_write;
        INT_ADDR = cur_addr;
        EXT_AD_O = (state == ST_DATA) ? cur_wdata : cur_addr;
        EXT_ASTB = (state == ST_ADDR) & is_ext_cur;
        EXT_RD_N = ~((state == ST_DATA) & is_ext_cur & ~cur_write);
        EXT_WR_N = ~((state == ST_DATA) & is_ext_cur & cur_write);
        EXT_WIDTH16 = is_ext_cur ? memory_expansion_mode_reg[MODE_EXT16_BIT] : 1'b1;
        EXT_CTRL_OE_N = RST | ~memory_expansion_mode_reg[MODE_EXTEN_BIT];
        EXT_AD_OE_N = RST | ~(is_ext_cur & ((state == ST_ADDR) | (state == ST_AWAIT)
                      | ((state == ST_DATA) & cur_write)));
        WATCHDOG_TIMEOUT_OUT = WATCHDOG_TIMEOUT_IN;
    end

    // Helper: cycles since acceptance and the expected length of the cycle.
    logic [5:0] age;
    logic [5:0] expect_len;
    always_ff @(posedge CLK) begin
        if (RST) begin
            age <= 6'd0;
            expect_len <= 6'd0;
        end else if (REQ_VALID & REQ_READY) begin
            age <= 6'd1;
            expect_len <= {3'b000, base} + {4'b0000, waits} + {5'b00000, aw}
                          + {5'b00000, ~hsf} + {3'b000, sync_pad};
        end else begin
            age <= age + 6'd1;
        end
    end

    AST_LENGTH: assert property (@(posedge CLK) disable iff (RST)
        RESP_VALID & ~RESP.fault |-> age == expect_len + 6'd1)
        else $error("Bus cycle length differs from the selected setting.");
    AST_AWAIT_ONE: assert property (@(posedge CLK) disable iff (RST)
        state == ST_AWAIT |=> state == ST_DATA)
        else $error("Address wait lasted more than one cycle.");
    AST_PRAM_FAST: assert property (@(posedge CLK) disable iff (RST)
        REQ_VALID & REQ_READY & area == AREA_PRAM & REQ.fetch
        |=> state == ST_DATA ##1 RESP_VALID)
        else $error("Peripheral RAM fetch was not single cycle.");
    AST_MRAM_REFUSE: assert property (@(posedge CLK) disable iff (RST)
        REQ_VALID & REQ_READY & area == AREA_MRAM & REQ.fetch
        |=> RESP_VALID & RESP.fault & state == ST_IDLE)
        else $error("Fetch from main RAM was not refused.");
    AST_MRAM_TWO: assert property (@(posedge CLK) disable iff (RST)
        REQ_VALID & REQ_READY & area == AREA_MRAM & ~REQ.fetch
        |=> state == ST_ADDR ##1 state == ST_DATA [*2] ##1 RESP_VALID)
        else $error("Main RAM access did not take two data cycles.");
    AST_MODE_ZERO: assert property (@(posedge CLK) disable iff (RST)
        (memory_expansion_mode_reg & ~MODE_WMASK) == 8'h00)
        else $error("Fixed mode bits are not zero.");
    AST_WAIT_ZERO: assert property (@(posedge CLK) disable iff (RST)
        programmable_wait_ctrl_reg[13:8] == 6'h00)
        else $error("Fixed wait-control bits are not zero.");
    AST_FLOAT: assert property (@(posedge CLK)
        RST |-> EXT_AD_OE_N & EXT_CTRL_OE_N)
        else $error("Pins driven during reset.");
    AST_SFR_WAITS: assert property (@(posedge CLK) disable iff (RST)
        state == ST_ADDR & cur_area == AREA_XSFR
        |-> cnt[3:0] == {2'b00, programmable_wait_ctrl_reg[SFR_WAIT_LSB +: 2]}
            + {1'b0, cur_write ? 3'd0 : SYNC_CYCLES})
        else $error("External register area waits not from bits 7 and 6.");
    AST_STROBE_HELD: assert property (@(posedge CLK) disable iff (RST)
        ~EXT_RD_N & cnt[3:0] != 4'd0 |=> ~EXT_RD_N)
        else $error("Read strobe released before waits ended.");
    AST_RESET_NORMAL: assert property (@(posedge CLK)
        $fell(RST) |-> programmable_wait_ctrl_reg[15:14] == 2'b00)
        else $error("Reset did not select normal fetch.");

    COV_EXT_WAIT: cover property (@(posedge CLK) disable iff (RST)
        state == ST_DATA & is_ext_cur & cnt[3:0] != 4'd0);
    COV_AWAIT: cover property (@(posedge CLK) disable iff (RST) state == ST_AWAIT);
    COV_FAULT: cover property (@(posedge CLK) disable iff (RST) RESP_VALID & RESP.fault);
    COV_ROM_READ: cover property (@(posedge CLK) disable iff (RST)
        RESP_VALID & cur_area == AREA_ROM);
endmodule
`default_nettype wire

// *** mabc_ext_mem.sv ***
// Behavioural external memory on the multiplexed address and data bus.
`timescale 1ns/100ps
`default_nettype none
module mabc_ext_mem (
    input wire logic clk,
    input wire logic [15:0] ad_o,
    input wire logic ad_oe_n,
    input wire logic astb,
    input wire logic rd_n,
    input wire logic wr_n,
    output logic [15:0] ad_i
);
    logic [15:0] mem [16];
    logic [15:0] addr = '0;
    logic [15:0] last = '0;
    // Latches the address on the strobe and stores data while writing.
    always @(posedge clk) begin
        if (astb === 1'b1) begin
            addr <= ad_o;
        end
        if (wr_n === 1'b0 && ad_oe_n === 1'b0) begin
            mem[addr[4:1]] <= ad_o;
        end
        if (rd_n === 1'b0) begin
            last <= mem[addr[4:1]];
        end
    end
    // Drives data only while the read strobe is low, else the inverse of the last value.
    assign ad_i = (rd_n === 1'b0) ? mem[addr[4:1]] : ~last;
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the bus-cycle control block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import mabc_pkg::*;
    logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, REQ_VALID = 0;
    logic [11:0] PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA, rd;
    logic PREADY, PSLVERR, REQ_READY, RESP_VALID, INT_SEL, INT_WRITE, err, saw_astb;
    mabc_req_t REQ = '0;
    mabc_resp_t RESP;
    logic [15:0] INT_ADDR, EXT_AD_O, EXT_AD_I, wd;
    logic [15:0] INT_RDATA = '0;
    logic EXT_AD_OE_N, EXT_ASTB, EXT_RD_N, EXT_WR_N, EXT_CTRL_OE_N, EXT_WIDTH16;
    logic WATCHDOG_TIMEOUT_IN = 1, WATCHDOG_TIMEOUT_OUT;
    int mismatches = 0, checks = 0, cyc = 0, lat, l0;
    logic [16:0] exp_q[$], e_m;
    bit cmp_q[$], c_m;
    always #50 CLK = ~CLK;
    mabc_top dut (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
        .PSLVERR, .REQ_VALID, .REQ, .REQ_READY, .RESP_VALID, .RESP, .INT_SEL, .INT_WRITE,
        .INT_ADDR, .INT_RDATA, .EXT_AD_O, .EXT_AD_OE_N, .EXT_AD_I, .EXT_ASTB, .EXT_RD_N,
        .EXT_WR_N, .EXT_CTRL_OE_N, .EXT_WIDTH16, .WATCHDOG_TIMEOUT_IN, .WATCHDOG_TIMEOUT_OUT);
    mabc_ext_mem mem (.clk(CLK), .ad_o(EXT_AD_O), .ad_oe_n(EXT_AD_OE_N), .astb(EXT_ASTB),
        .rd_n(EXT_RD_N), .wr_n(EXT_WR_N), .ad_i(EXT_AD_I));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic done(input int n);
        $display("Test %0d done", n);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        check(rd, e);
    endtask
    // Issues one request, notes the expected answer and counts cycles to the response.
    task automatic cpu(input logic [15:0] a, input logic f, input logic w, input logic [16:0] e,
        input bit c);
        @(posedge CLK);
        REQ_VALID <= 1'b1;
        REQ <= '{a, f, w, wd};
        exp_q.push_back(e);
        cmp_q.push_back(c);
        do @(posedge CLK); while (REQ_READY !== 1'b1);
        REQ_VALID <= 1'b0;
        saw_astb = 1'b0;
        lat = 0;
        do begin
            @(negedge CLK);
            lat++;
        end while (RESP_VALID !== 1'b1);
    endtask
    task automatic acc(input logic [15:0] wv, input logic [15:0] a, input logic f,
        input logic [16:0] e, input bit c);
        apb(1'b1, OFF_WAIT, {16'h0000, wv});
        cpu(a, f, 1'b0, e, c);
    endtask
    // Compares each response with the oldest note.
    always @(negedge CLK) begin
        if (EXT_ASTB === 1'b1) begin
            saw_astb = 1'b1;
        end
        if (INT_SEL === 1'b1) begin
            check(EXT_WIDTH16, 1'b1);
            check({INT_WRITE, INT_ADDR}, {REQ.write, REQ.addr});
        end
        if (RESP_VALID === 1'b1 && exp_q.size() > 0) begin
            e_m = exp_q.pop_front();
            c_m = cmp_q.pop_front();
            check(RESP.fault, e_m[0]);
            if (c_m) begin
                check(RESP.rdata, e_m[16:1]);
            end
        end
    end
    always @(posedge CLK) begin
        cyc++;
        INT_RDATA <= 16'($urandom);
        if (cyc > 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'hbf9a9640));
        repeat (11) @(posedge CLK);
        @(negedge CLK);
        check(EXT_AD_OE_N, 1'b1);
        check(EXT_CTRL_OE_N, 1'b1);
        check(WATCHDOG_TIMEOUT_OUT, 1'b1);
        @(posedge CLK);
        RST <= 1'b0;
        rchk(OFF_MODE, 32'h0000_0004);
        rchk(OFF_WAIT, 32'h0000_0000);
        done(1);
        apb(1'b1, OFF_MODE, 32'h0000_009C);
        rchk(OFF_MODE, 32'h0000_0004);
        apb(1'b1, OFF_WAIT, 32'h0000_3F00);
        rchk(OFF_WAIT, 32'h0000_0000);
        apb(1'b0, 12'h00C, '0);
        check(err, 1'b1);
        apb(1'b1, OFF_MODE, 32'h0000_0064);
        done(2);
        wd = 16'($urandom);
        cpu(16'h9006, 1'b0, 1'b1, '0, 1'b0);
        for (int w = 0; w < 4; w++) begin
            acc(16'(w << 4), 16'h9006, 1'b0, {wd, 1'b0}, 1'b1);
            if (w == 0) begin
                l0 = lat;
            end
            check(lat, l0 + w);
        end
        acc(16'h0002, 16'h9006, 1'b0, {wd, 1'b0}, 1'b1);
        check(lat, l0 + 1);
        done(3);
        acc(16'h0000, 16'hFFD0, 1'b0, '0, 1'b0);
        l0 = lat;
        acc(16'h0033, 16'hFFD0, 1'b0, '0, 1'b0);
        check(lat, l0);
        acc(16'h0080, 16'hFFD0, 1'b0, '0, 1'b0);
        check(lat, l0 + 2);
        done(4);
        for (int i = 0; i < 2; i++) begin
            acc(16'h0000, i ? 16'hFE00 : 16'hF800, 1'b0, '0, 1'b0);
            l0 = lat;
            acc(16'h00FF, i ? 16'hFE00 : 16'hF800, 1'b0, '0, 1'b0);
            check(lat, l0);
        end
        cpu(16'hFE00, 1'b1, 1'b0, 17'h0_0001, 1'b0);
        cpu(16'hF800, 1'b1, 1'b0, '0, 1'b0);
        rchk(OFF_STAT, 32'h0000_0024);
        done(5);
        acc(16'h0000, 16'h0100, 1'b1, '0, 1'b0);
        l0 = lat;
        acc(16'h000C, 16'h0100, 1'b1, '0, 1'b0);
        check(lat, l0 + 3);
        acc(16'h0001, 16'h0100, 1'b1, '0, 1'b0);
        check(lat, l0 + 1);
        acc(16'h4000, 16'h0100, 1'b1, '0, 1'b0);
        check(lat, l0 - 1);
        done(6);
        acc(16'h0000, 16'h8000, 1'b0, '0, 1'b0);
        check(saw_astb, 1'b1);
        apb(1'b1, OFF_MODE, 32'h0000_0065);
        cpu(16'h8000, 1'b0, 1'b0, '0, 1'b0);
        check(saw_astb, 1'b0);
        done(7);
        @(posedge CLK);
        RST <= 1'b1;
        @(negedge CLK);
        check(EXT_AD_OE_N, 1'b1);
        check(EXT_CTRL_OE_N, 1'b1);
        @(posedge CLK);
        RST <= 1'b0;
        rchk(OFF_MODE, 32'h0000_0004);
        rchk(OFF_WAIT, 32'h0000_0000);
        done(8);
        print_verdict();
    end
endmodule
`default_nettype wire
